// ### hw/mrb_mode_dev.sv
// ************************************************************
// Device end: mode settings and burst column order
// ************************************************************

// Operation
// - Load only with banks idle
// - Controller waits after each load
// - Each load carries every field
// - Settings kept until next load
// - Length four or eight from field
// - Block from upper column bits, wraps
// - Order bit picks sequential or interleaved
// - Length four order rule
// - Length eight nibble or xor order
// - Test bit blocks other fields
// - Loop reset bit self clears
// - Wait 200 cycles before read
// - Auto precharge after recovery count
// - Controller programs recovery two to eight
// - Exit type bit for active power-down
// - Read latency field four to seven
// - No reserved latency or recovery codes
// - First read data at n plus m
// - Posted latency holds reads internally
// - Both bank selects low address it
// - Total latencies from posted plus read
module mrb_mode_dev (
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                srst,
	// Link to controller
	mrb_link_if.device               link,
	// Extended setting from outside this block
	input  wire logic [2:0]          postedExtraLatency,
	// Settings seen by the array logic
	output logic                     burstLen8,
	output logic                     burstOrderSelect,
	output logic [2:0]               readLatency,
	output logic [2:0]               storeRecoveryCode,
	output logic                     slowExitSelect,
	output logic                     vendorTestMode,
	output logic                     loopResetPulse,
	output logic                     loopLocked
);
	import mrb_pkg::*;

	// Burst phases
	typedef enum logic [1:0] {
		PH_IDLE, PH_WAIT, PH_BURST, PH_RECOVER
	} mrb_phase_type;

	// All state of the device end
	typedef struct packed {
		logic [12:0]   modeSettings; // Stored mode word
		logic          testMode;     // Test mode entered
		logic          loopPulse;    // Loop reset event
		logic [7:0]    lockCnt;      // Cycles left to lock
		mrb_phase_type phase;        // Burst phase
		logic [3:0]    latCnt;       // Latency countdown
		logic [2:0]    beat;         // Beat index
		logic [2:0]    recCnt;       // Recovery countdown
		logic          isWrite;      // Burst is a write
		logic          autoPre;      // Burst precharges
		logic [9:0]    startCol;     // Starting column
		logic          dataValid;    // Beat strobe
		logic [9:0]    dataCol;      // Beat column
		logic          preStrobe;    // Precharge event
	} mrb_dev_state_type;

	mrb_dev_state_type st;        // Registered state
	mrb_dev_state_type next_st;   // Next state
	logic [2:0]        beatSel;   // Beat to order next
	logic [2:0]        orderCol;  // Ordered low column
	logic [3:0]        readTotal; // Total read latency
	logic [3:0]        writeTotal;// Total write latency
	logic              len8;      // Length eight active
	logic              lastBeat;  // Final beat of burst

	// ************************************************************
	// Decoded settings
	// ************************************************************
	// Code 011 means eight
	assign len8 = st.modeSettings[LEN_LSB +: 3] == LEN8_CODE;
	assign readTotal  = {1'b0, st.modeSettings[LAT_LSB +: 3]} + {1'b0, postedExtraLatency};
	assign writeTotal = readTotal - 4'h1;
	// Same length for reads and writes
	assign lastBeat = st.beat == (len8 ? 3'h7 : 3'h3);
	// Next beat index while bursting, else first
	assign beatSel  = (st.phase == PH_BURST) ? st.beat + 3'h1 : 3'h0;

	// Column order of the next beat
	mrb_burst_order i_mrb_burst_order (
		.startCol   (st.startCol[2:0]),
		.beatIdx    (beatSel),
		.len8       (len8),
		.interleave (st.modeSettings[ORDER_BIT]),
		.beatCol    (orderCol)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_st           = st;
		next_st.preStrobe = 1'b0;
		// Bit drops back after one cycle
		next_st.loopPulse = 1'b0;
		next_st.modeSettings[LOOP_BIT] = 1'b0;
		// Lock countdown after a loop reset
		if (st.lockCnt != 8'h0) begin
			next_st.lockCnt = st.lockCnt - 8'h1;
		end

		// Burst progress
		unique case (st.phase)
			PH_IDLE: begin
				next_st.dataValid = 1'b0;
			end
			PH_WAIT: begin
				// First read beat lands on edge n+m, first write beat one edge sooner
				if (st.latCnt == 4'h0) begin
					next_st.phase     = PH_BURST;
					next_st.beat      = 3'h0;
					next_st.dataValid = 1'b1;
					next_st.dataCol   = {st.startCol[9:3], orderCol};
				end else begin
					next_st.latCnt = st.latCnt - 4'h1;
				end
			end
			PH_BURST: begin
				if (lastBeat) begin
					next_st.dataValid = 1'b0;
					if (st.isWrite && st.autoPre) begin
						next_st.phase  = PH_RECOVER;
						next_st.recCnt = st.modeSettings[REC_LSB +: 3];
					end else begin
						next_st.phase  = PH_IDLE;
					end
				end else begin
					next_st.beat    = beatSel;
					next_st.dataCol = {st.startCol[9:3], orderCol};
				end
			end
			PH_RECOVER: begin
				// Field holds count minus one
				// Pulse lands count edges after the last beat; code 0 acts as 1
				if (st.recCnt <= 3'h1) begin
					next_st.preStrobe = 1'b1;
					next_st.phase     = PH_IDLE;
				end else begin
					next_st.recCnt = st.recCnt - 3'h1;
				end
			end
		endcase

		// Command decode
		unique case (link.cmd)
			CMD_LOAD: begin
				if (link.bankSel == MODE_BANK) begin
					if (link.addr[TEST_BIT]) begin
						next_st.testMode = 1'b1;
					end else begin
						next_st.modeSettings = link.addr;
						next_st.testMode     = 1'b0;
						// Start loop reset and lock count
						if (link.addr[LOOP_BIT]) begin
							next_st.loopPulse = 1'b1;
							next_st.lockCnt   = LOOP_LOCK_CK;
						end
					end
				end
			end
			CMD_READ, CMD_WRITE: begin
				// A new access replaces any burst in flight
				next_st.phase     = PH_WAIT;
				next_st.dataValid = 1'b0;
				next_st.isWrite   = link.cmd == CMD_WRITE;
				next_st.autoPre   = link.addr[AUTO_PRE_BIT];
				next_st.startCol  = link.addr[COL_W-1:0];
				next_st.latCnt = (link.cmd == CMD_WRITE ? writeTotal : readTotal) - 4'h2;
			end
			default: begin
				// Other commands leave this block alone
			end
		endcase
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			st              <= '0;
			st.modeSettings <= MODE_RESET;
			st.phase        <= PH_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign link.dataValid = st.dataValid;
	assign link.dataCol   = st.dataCol;
	assign link.preStrobe = st.preStrobe;
	// Order bit out to the array
	assign burstOrderSelect  = st.modeSettings[ORDER_BIT];
	assign burstLen8         = len8;
	assign readLatency       = st.modeSettings[LAT_LSB +: 3];
	assign storeRecoveryCode = st.modeSettings[REC_LSB +: 3];
	assign slowExitSelect    = st.modeSettings[EXIT_BIT];
	assign vendorTestMode    = st.testMode;
	assign loopResetPulse    = st.loopPulse;
	assign loopLocked        = st.lockCnt == 8'h0;

endmodule : mrb_mode_dev

// ### hw/mrb_pkg.sv
package mrb_pkg;

	// ************************************************************
	// Mode word field positions
	// ************************************************************
	localparam int MODE_W      = 13;
	localparam int LEN_LSB     = 0;
	localparam int ORDER_BIT   = 3;
	localparam int LAT_LSB     = 4;
	localparam int TEST_BIT    = 7;
	localparam int LOOP_BIT    = 8;
	localparam int REC_LSB     = 9;
	localparam int EXIT_BIT    = 12;
	localparam int COL_W       = 10;
	localparam int AUTO_PRE_BIT = 10;

	// ************************************************************
	// Field codes and reset values
	// ************************************************************
	localparam logic [2:0] LEN4_CODE  = 3'h2;
	localparam logic [2:0] LEN8_CODE  = 3'h3;
	localparam logic [2:0] LAT_MIN    = 3'h4;
	localparam logic [2:0] LAT_MAX    = 3'h7;
	localparam logic [2:0] REC_MIN    = 3'h1;
	localparam logic [12:0] MODE_RESET = 13'h0042;
	localparam logic [1:0] MODE_BANK  = 2'h0;

	// ************************************************************
	// Timing counts in clock cycles
	// ************************************************************
	localparam logic [7:0] LOOP_LOCK_CK   = 8'hc8;
	localparam logic [3:0] MODE_LOAD_WAIT = 4'h2;
	localparam logic [5:0] BURST_GUARD    = 6'h1e;

	// ************************************************************
	// Host register offsets and status bits
	// ************************************************************
	localparam logic [3:0] REG_MODE   = 4'h0;
	localparam logic [3:0] REG_ACCESS = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam int OP_LSB      = 12;
	localparam int ST_READY    = 0;
	localparam int ST_LOCKED   = 1;
	localparam int ST_REFUSED  = 2;
	localparam int ST_ROW_OPEN = 3;

	// Link commands
	typedef enum logic [2:0] {
		CMD_NOP, CMD_LOAD, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE
	} mrb_cmd_type;

endpackage : mrb_pkg

// ### hw/mrb_link_if.sv
// Command link between controller and device, one clock
interface mrb_link_if;
	import mrb_pkg::*;
	mrb_cmd_type cmd;       // Command in this cycle
	logic [1:0]  bankSel;   // Bank select
	logic [12:0] addr;      // Address or mode word
	logic        dataValid; // Burst beat present
	logic [9:0]  dataCol;   // Column of this beat
	logic        preStrobe; // Internal auto precharge done
	modport device (input cmd, bankSel, addr, output dataValid, dataCol, preStrobe);
	modport ctrl (output cmd, bankSel, addr, input dataValid, dataCol, preStrobe);
endinterface : mrb_link_if

// ### hw/mrb_burst_order.sv
// Column order of one beat inside a burst block
module mrb_burst_order (
	// Burst setup
	input  wire logic [2:0] startCol,
	input  wire logic [2:0] beatIdx,
	input  wire logic       len8,
	input  wire logic       interleave,
	// Beat column
	output logic      [2:0] beatCol
);
	import mrb_pkg::*;

	// ************************************************************
	// Order generator
	// ************************************************************
	always_comb begin
		if (interleave) begin
			beatCol = startCol ^ (len8 ? beatIdx : {1'b0, beatIdx[1:0]});
		end else begin
			beatCol[1:0] = startCol[1:0] + beatIdx[1:0];
			beatCol[2]   = startCol[2] ^ (len8 & beatIdx[2]);
		end
	end

endmodule : mrb_burst_order

// ### hw/mrb_mode_ctrl.sv
// Controller end: issues loads and accesses from software writes
module mrb_mode_ctrl (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// Link to device
	mrb_link_if.ctrl         link,
	// Software register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdData
);
	import mrb_pkg::*;

	// All state of the controller end
	typedef struct packed {
		mrb_cmd_type cmd;       // Command on the link
		logic [12:0] addr;      // Address on the link
		logic [12:0] lastMode;  // Last mode word sent
		logic [3:0]  loadWait;  // Wait after a load
		logic [7:0]  lockWait;  // Wait before reads
		logic [5:0]  guard;     // Burst still running
		logic        rowOpen;   // Some row active
		logic        refused;   // Sticky refusal
		logic [31:0] rdData;    // Read data
	} mrb_ctrl_state_type;

	mrb_ctrl_state_type st;      // Registered state
	mrb_ctrl_state_type next_st; // Next state
	logic               ready;   // Free to issue
	logic [1:0]         op;      // Access op field

	assign ready = st.loadWait == 4'h0;
	assign op    = regWrData[OP_LSB +: 2];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_st        = st;
		next_st.cmd    = CMD_NOP;
		next_st.rdData = 32'h0;
		if (st.loadWait != 4'h0) begin
			next_st.loadWait = st.loadWait - 4'h1;
		end
		if (st.lockWait != 8'h0) begin
			next_st.lockWait = st.lockWait - 8'h1;
		end
		if (st.guard != 6'h0) begin
			next_st.guard = st.guard - 6'h1;
		end
		if (link.preStrobe) begin
			next_st.rowOpen = 1'b0;
		end
		// Status read clears the sticky flag
		if (regRd) begin
			unique case (regAddr)
				REG_MODE:   next_st.rdData = {19'h0, st.lastMode};
				REG_STATUS: begin
					next_st.rdData[ST_READY]    = ready;
					next_st.rdData[ST_LOCKED]   = st.lockWait == 8'h0;
					next_st.rdData[ST_REFUSED]  = st.refused;
					next_st.rdData[ST_ROW_OPEN] = st.rowOpen;
					next_st.refused = 1'b0;
				end
				default:    next_st.rdData = 32'h0;
			endcase
		end
		if (regWr && regAddr == REG_MODE) begin
			// Banks idle, no burst; legal codes
			if (!ready || st.rowOpen || st.guard != 6'h0
					|| regWrData[LAT_LSB +: 3] < LAT_MIN
					|| regWrData[REC_LSB +: 3] < REC_MIN) begin
				next_st.refused = 1'b1;
			end else begin
				// Full word; test bit kept low
				next_st.cmd      = CMD_LOAD;
				next_st.addr     = regWrData[12:0] & ~(13'h1 << TEST_BIT);
				next_st.lastMode = next_st.addr;
				next_st.loadWait = MODE_LOAD_WAIT;
				if (regWrData[LOOP_BIT]) begin
					next_st.lockWait = LOOP_LOCK_CK;
				end
			end
		end else if (regWr && regAddr == REG_ACCESS) begin
			if (!ready || (op == 2'h1 && st.lockWait != 8'h0)) begin
				next_st.refused = 1'b1;
			end else begin
				next_st.addr = regWrData[12:0];
				unique case (op)
					2'h0: begin
						next_st.cmd     = CMD_ACT;
						next_st.rowOpen = 1'b1;
					end
					2'h1: begin
						next_st.cmd   = CMD_READ;
						next_st.guard = BURST_GUARD;
					end
					2'h2: begin
						next_st.cmd   = CMD_WRITE;
						next_st.guard = BURST_GUARD;
					end
					2'h3: begin
						next_st.cmd     = CMD_PRE;
						next_st.rowOpen = 1'b0;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			st     <= '0;
			st.cmd <= CMD_NOP;
		end else begin
			st <= next_st;
		end
	end

	// Outputs from registers; bank select tied to MODE_BANK
	assign link.cmd     = st.cmd;
	assign link.bankSel = MODE_BANK;
	assign link.addr    = st.addr;
	assign regRdData    = st.rdData;

endmodule : mrb_mode_ctrl

// ### dv/mrb_mode_props.sv
// Watches the command link between the two ends
module mrb_mode_props (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 srst,
	// Link signals
	input  wire mrb_pkg::mrb_cmd_type cmd,
	input  wire logic [1:0]           bankSel,
	input  wire logic [12:0]          addr,
	input  wire logic                 dataValid,
	input  wire logic [9:0]           dataCol,
	input  wire logic                 preStrobe
);
	import mrb_pkg::*;
	// Loaded length, order and recovery, cycles since the last beat
	typedef struct packed {
		logic       len8;
		logic       il;
		logic [2:0] rec;
		logic [4:0] since;
	} mrb_watch_type;
	mrb_watch_type st;      // Watch state
	mrb_watch_type next_st; // Next watch state

	// ************************************************************
	// Helper logic
	// ************************************************************
	// Follow accepted loads and count quiet cycles after a beat
	always_comb begin
		next_st = st;
		if (cmd == CMD_LOAD && bankSel == MODE_BANK && !addr[TEST_BIT]) begin
			next_st.len8 = (addr[2:0] == LEN8_CODE);
			next_st.il   = addr[ORDER_BIT];
			next_st.rec  = addr[11:9];
		end
		// Restart on a beat, saturate when idle
		if (dataValid) begin
			next_st.since = 5'h01;
		end else if (st.since != 5'h1f) begin
			next_st.since = st.since + 5'h01;
		end
	end
	// Register the watch state, reset mode word fields
	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '{len8: 1'b0, il: 1'b0, rec: 3'h0, since: 5'h1f};
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	bank_zero_a: assert property (cmd != CMD_NOP |-> bankSel == MODE_BANK)
		else $error("bank select not zero");
	load_quiet_a: assert property (cmd == CMD_LOAD |=> cmd == CMD_NOP)
		else $error("command right after load");
	test_clear_a: assert property (cmd == CMD_LOAD |-> !addr[TEST_BIT])
		else $error("load with test bit set");
	idle_load_a: assert property (dataValid |-> cmd != CMD_LOAD)
		else $error("load during burst");
	len4_beats_a: assert property ($rose(dataValid) && !st.len8 |-> dataValid[*4] ##1 !dataValid)
		else $error("length four burst wrong size");
	len8_beats_a: assert property ($rose(dataValid) && st.len8 |-> dataValid[*8] ##1 !dataValid)
		else $error("length eight burst wrong size");
	block_hold_a: assert property (dataValid && $past(dataValid) |->
		dataCol[9:3] == $past(dataCol[9:3]) && (st.len8 || dataCol[2] == $past(dataCol[2])))
		else $error("burst left its block");
	seq_step_a: assert property (dataValid && $past(dataValid) && !st.il |->
		dataCol[1:0] == $past(dataCol[1:0]) + 2'h1)
		else $error("sequential step wrong");
	read_lat_a: assert property (cmd == CMD_READ |-> ##[4:13] dataValid)
		else $error("read data late");
	write_lat_a: assert property (cmd == CMD_WRITE |-> ##[3:12] dataValid)
		else $error("write beats late");
	pre_time_a: assert property (preStrobe |-> st.since == {2'h0, st.rec} + 5'h01)
		else $error("auto precharge at wrong time");

	// Main scenarios reached
	load_seen_c: cover property (cmd == CMD_LOAD);
	pre_seen_c: cover property (preStrobe);
	il8_seen_c: cover property ($rose(dataValid) && st.len8 && st.il);
endmodule : mrb_mode_props

// ### dv/mrb_ddr2_mode_register_burst_order_test.sv
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module mrb_ddr2_mode_register_burst_order_test;
	timeunit 1ns;
	timeprecision 1ns;
	import mrb_pkg::*;
	// Clock, reset and register port
	logic        mclk, srst, regWr, regRd;
	logic [3:0]  regAddr;
	logic [31:0] regWrData, regRdData, st, rs, r;
	logic [2:0]  postedExtraLatency, readLatency, storeRecoveryCode;
	logic        burstLen8, burstOrderSelect, slowExitSelect, vendorTestMode;
	logic        loopResetPulse, loopLocked;
	// Expected settings
	logic        len8, il, ex;
	logic [2:0]  lat, rec, al;
	logic [9:0]  col;
	int          error_cnt, cmp_count, k, i;

	mrb_link_if link ();
	mrb_mode_dev i_mrb_mode_dev (.mclk(mclk), .srst(srst), .link(link),
		.postedExtraLatency(postedExtraLatency), .burstLen8(burstLen8),
		.burstOrderSelect(burstOrderSelect), .readLatency(readLatency),
		.storeRecoveryCode(storeRecoveryCode), .slowExitSelect(slowExitSelect),
		.vendorTestMode(vendorTestMode), .loopResetPulse(loopResetPulse),
		.loopLocked(loopLocked));
	mrb_mode_ctrl i_mrb_mode_ctrl (.mclk(mclk), .srst(srst), .link(link), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	mrb_mode_props i_mrb_mode_props (.mclk(mclk), .srst(srst), .cmd(link.cmd),
		.bankSel(link.bankSel), .addr(link.addr), .dataValid(link.dataValid),
		.dataCol(link.dataCol), .preStrobe(link.preStrobe));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// Mode word from the expected settings
	function automatic logic [31:0] word(input logic [2:0] l, input logic [2:0] c,
		input logic lr, input logic e);
		return {19'h0, e, c, lr, 1'b0, l, il, len8 ? LEN8_CODE : LEN4_CODE};
	endfunction : word
	// Column of beat b from start column s
	function automatic logic [9:0] order(input logic [9:0] s, input logic [2:0] b);
		logic [1:0] lo;
		lo = il ? (s[1:0] ^ b[1:0]) : (s[1:0] + b[1:0]);
		return {s[9:3], s[2] ^ (len8 & b[2]), lo};
	endfunction : order
	task automatic tally_and_finish();
		$display("compares=%0d errors=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	// A wait that used up its bound ends the run as a failure
	task automatic expire(input logic hit);
		if (hit) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : expire
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask : rd
	task automatic chk_mode();
		`CHK(burstLen8, len8)
		`CHK(burstOrderSelect, il)
		`CHK(readLatency, lat)
		`CHK(storeRecoveryCode, rec)
		`CHK(slowExitSelect, ex)
		`CHK(vendorTestMode, 1'b0)
	endtask : chk_mode
	// One access burst: latency, beat columns and auto precharge
	task automatic burst(input logic [1:0] op, input logic ap, input int m);
		int b;
		int d;
		wr(REG_ACCESS, {18'h0, op, 1'b0, ap, col});
		b = -1;
		do begin
			@(negedge mclk);
			b++;
		end while (!link.dataValid && b < 20);
		if (!link.dataValid) begin
			error_cnt++;
			tally_and_finish();
		end
		`CHK(b, m)
		for (b = 0; b < (len8 ? 8 : 4); b++) begin
			`CHK(link.dataValid, 1'b1)
			`CHK(link.dataCol, order(col, b[2:0]))
			@(negedge mclk);
		end
		`CHK(link.dataValid, 1'b0)
		for (d = 1; ap && !link.preStrobe && d < 12; d++) begin
			@(negedge mclk);
		end
		expire(ap && !link.preStrobe);
		if (ap) begin
			`CHK(d, int'(rec) + 1)
		end
	endtask : burst

	// ************************************************************
	// Stimulus
	// ************************************************************
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Cut a hang short
	initial begin
		repeat (100000) @(posedge mclk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{srst, regAddr, regWrData, regWr, regRd, postedExtraLatency} = {1'b1, 41'h0};
		{len8, il, ex, lat, rec, rs} = {3'h0, 3'h4, 3'h0, 32'd18659};
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		chk_mode();
		`CHK(loopLocked, 1'b1)
		// Loop reset: pulse, self clear, reads held off
		{len8, lat, rec} = {1'b1, 3'h5, 3'h2};
		wr(REG_MODE, word(lat, rec, 1'b1, ex));
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (!loopResetPulse && k < 8);
		expire(!loopResetPulse);
		@(negedge mclk);
		`CHK(loopResetPulse, 1'b0)
		`CHK(loopLocked, 1'b0)
		// Host copy keeps the word as sent; only the device clears its bit
		rd(REG_MODE, st);
		`CHK(st, word(lat, rec, 1'b1, ex))
		wr(REG_ACCESS, 32'h1000);
		rd(REG_STATUS, st);
		`CHK(st[ST_REFUSED], 1'b1)
		for (k = 0; !loopLocked && k < 250; k++) @(negedge mclk);
		expire(!loopLocked);
		`CHK(k > 180 && k < 250, 1'b1)
		// Reserved latency refused, test bit never reaches the device
		wr(REG_MODE, word(3'h3, rec, 1'b0, ex));
		rd(REG_STATUS, st);
		`CHK(st[ST_REFUSED], 1'b1)
		rd(REG_STATUS, st);
		`CHK(st[ST_REFUSED], 1'b0)
		wr(REG_MODE, word(lat, rec, 1'b0, ex) | 32'h80);
		repeat (4) @(posedge mclk);
		chk_mode();
		rd(4'hc, st);
		`CHK(st, 32'h0)
		// Random settings with boundary recovery codes and a wrapping column
		for (i = 0; i < 12; i++) begin
			r = rnd();
			{len8, il, ex, lat} = {r[2:0], 3'h4 + {1'b0, r[4:3]}};
			rec = (i == 0) ? 3'h1 : ((i == 1 || r[7:5] == 3'h0) ? 3'h7 : r[7:5]);
			al = (r[10:8] == 3'h7) ? 3'h6 : r[10:8];
			col = (i < 2) ? 10'h3ff : r[20:11];
			postedExtraLatency <= al;
			wr(REG_MODE, word(lat, rec, 1'b0, ex));
			repeat (4) @(posedge mclk);
			chk_mode();
			wr(REG_ACCESS, 32'h0);
			burst(2'h2, 1'b1, int'(lat) + int'(al) - 1);
			wr(REG_ACCESS, 32'h0);
			col = col ^ r[30:21];
			burst(2'h1, 1'b0, int'(lat) + int'(al));
			wr(REG_ACCESS, 32'h3000);
			repeat (32) @(posedge mclk);
			rd(REG_STATUS, st);
			`CHK(st[3:1], 3'h1)
		end
		tally_and_finish();
	end
endmodule : mrb_ddr2_mode_register_burst_order_test
